// *** logic/isb_pkg.sv ***
// shared constants for the interpolation set-point buffer
package isb_pkg;
  // object indices and subindices
  localparam logic [15:0] IDX_RECORD = 16'h60c1;
  localparam logic [15:0] IDX_TIME = 16'h60c2;
  localparam logic [15:0] IDX_CFG = 16'h60c4;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_SETPOINT = 8'h01;
  localparam logic [7:0] SUB_MANTISSA = 8'h01;
  localparam logic [7:0] SUB_EXPONENT = 8'h02;
  localparam logic [7:0] SUB_CAPACITY = 8'h01;
  localparam logic [7:0] SUB_FILL = 8'h02;
  localparam logic [7:0] SUB_LAYOUT = 8'h03;
  localparam logic [7:0] SUB_SLOT = 8'h04;
  localparam logic [7:0] SUB_RECSIZE = 8'h05;
  localparam logic [7:0] SUB_FLUSH = 8'h06;
  // values after reset and fixed readbacks
  localparam logic [7:0] RECORD_COUNT_VAL = 8'h01;
  localparam logic [7:0] TIME_COUNT_VAL = 8'h02;
  localparam logic [7:0] CFG_COUNT_VAL = 8'h06;
  localparam logic [7:0] MANTISSA_RST = 8'h01;
  localparam logic [7:0] EXPONENT_RST = 8'hfd;
  localparam logic [31:0] FILL_CFG_RST = 32'h00000001;
  localparam logic [7:0] LAYOUT_RST = 8'h00;
  localparam logic [15:0] SLOT_RST = 16'h0001;
  localparam logic [7:0] RECSIZE_RST = 8'h04;
  // control codes
  localparam logic [7:0] LAYOUT_FIFO = 8'h00;
  localparam logic [7:0] LAYOUT_RING = 8'h01;
  localparam logic [7:0] FLUSH_CLEAR = 8'h00;
  localparam logic [7:0] FLUSH_ENABLE = 8'h01;
  localparam logic [7:0] RECORD_BYTES = 8'h04;
  // buffer shape
  localparam int BUF_WIDTH = 32;
  localparam int BUF_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
  // time base of the cycle-time result
  localparam int NS_EXP_OFFSET = 9;
  localparam int EXP_MIN = -9;
  localparam int EXP_MAX = 0;
  localparam int CYC_W = 40;
endpackage

// *** logic/isb_stream_if.sv ***
// valid/ready word stream between the buffer and its users
`timescale 1ns/1ns
`default_nettype none
interface isb_stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** logic/isb_fifo.sv ***
// flip-flop fifo with flush and fill count
`timescale 1ns/1ns
`default_nettype none
module isb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic flush,
  output logic [CW-1:0] count,
  // streams
  isb_stream_if.snk wr,
  isb_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // a full buffer still takes a word when one leaves in the same cycle
  assign wr.ready = (cnt_q != CW'(DEPTH)) || (rd.ready && rd.valid);
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rp_q];
  assign count = cnt_q;
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // next pointers, count and storage; flush drops everything
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        mem_d[wp_q] = wr.data;
        wp_d = wp_q + AW'(1);
      end
      if (pop) begin
        rp_d = rp_q + AW'(1);
      end
      cnt_d = cnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset, empty slots are never read
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
  end
endmodule
`default_nettype wire

// *** logic/isb_cycle_calc.sv ***
// cycle time in nanoseconds from mantissa and power-of-ten exponent
`timescale 1ns/1ns
`default_nettype none
module isb_cycle_calc
  import isb_pkg::*;
(
  // operands
  input wire logic [7:0] mantissa,
  input wire logic [7:0] exponent,
  // result
  output logic [CYC_W-1:0] cycle_ns,
  output logic in_range
);
  int e;

  // ten to the n, small n only
  function automatic logic [CYC_W-1:0] pow10(input int n);
    logic [CYC_W-1:0] r;
    r = CYC_W'(1);
    for (int i = 0; i < n; i++) begin
      r = CYC_W'(r * CYC_W'(10));
    end
    return r;
  endfunction

  // seconds scaled to ns; exponents below ns resolution or above 1 s report 0
  always_comb begin
    e = int'($signed(exponent));
    in_range = (e >= EXP_MIN) && (e <= EXP_MAX);
    cycle_ns = '0;
    if (in_range) begin
      cycle_ns = CYC_W'({32'h0, mantissa} * pow10(e + NS_EXP_OFFSET)); // [R3]
    end
  end
endmodule
`default_nettype wire

// *** logic/isb_setpoint_buffer.sv ***
// interpolation set-point buffer with its object-dictionary entries
//
// Operation
// [R1] set-point data is the demand position used while interpolation is active
// [R2] a written set-point takes effect only at the next sync instant
// [R3] cycle time equals mantissa times ten to the exponent, in seconds
// [R4] host keeps the exponent at minus three, giving a millisecond base
// [R5] a read-only entry reports the most records the buffer holds
// [R6] an entry gives the number of records currently held
// [R7] organization zero means fifo, one means ring buffer
// [R8] a 16-bit entry points at the next free slot to write
// [R9] write-only record size counts bytes per record
// [R10] flush code zero drops all records and blocks buffer access
// [R11] flush code one opens the buffer to new records
// [R12] capacity, organization, record size and flush are separate entries
// [R13] ring mode wraps the free-slot pointer to one after the configured size
`timescale 1ns/1ns
`default_nettype none
module isb_setpoint_buffer
  import isb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // object-dictionary access
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata_q,
  output logic od_ack_q,
  output logic od_err_q,
  // set-point mapped in receive process data
  input wire logic pdo_wr,
  input wire logic [31:0] pdo_setpoint,
  output logic pdo_ready_q,
  // motion side
  input wire logic sync,
  input wire logic interp_active,
  output logic [31:0] demand_pos_q,
  output logic demand_valid_q,
  output logic [CYC_W-1:0] cycle_ns_q,
  output logic cycle_ok_q,
  output logic buffer_access_q
);
  // configuration state
  logic [7:0] mantissa_q, mantissa_d;
  logic [7:0] exponent_q, exponent_d;
  logic [31:0] fill_cfg_q, fill_cfg_d;
  logic [7:0] layout_q, layout_d;
  logic [15:0] slot_q, slot_d;
  logic [7:0] recsize_q, recsize_d;
  logic access_q, access_d;
  logic [31:0] last_sp_q, last_sp_d;
  // answer and output state
  logic [31:0] rdata_d;
  logic ack_d, err_d;
  logic ready_d;
  logic [31:0] demand_d;
  logic dvalid_d;
  logic [CYC_W-1:0] cyc_ns;
  logic cyc_ok;
  // buffer plumbing
  logic [CNT_W-1:0] cnt, cnt_n, limit, limit_n;
  logic flush, accept, od_sp, push, overwrite, sync_pop;
  logic [31:0] push_data;
  logic ring, ring_n;
  logic hit_rec, hit_time, hit_cfg;

  isb_stream_if #(.WIDTH(BUF_WIDTH)) in_s ();
  isb_stream_if #(.WIDTH(BUF_WIDTH)) out_s ();

  isb_fifo #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH),
    .CW(CNT_W)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .count(cnt),
    .wr(in_s),
    .rd(out_s)
  );

  isb_cycle_calc u_calc (
    .mantissa(mantissa_q),
    .exponent(exponent_q),
    .cycle_ns(cyc_ns),
    .in_range(cyc_ok)
  );

  // configured size clamped to 1..depth, zero treated as one
  function automatic logic [CNT_W-1:0] clamp_size(input logic [31:0] v);
    if (v == 32'h0) begin
      return CNT_W'(1);
    end else if (v > 32'(BUF_DEPTH)) begin
      return DEPTH_CNT;
    end
    return CNT_W'(v);
  endfunction

  assign hit_rec = (od_index == IDX_RECORD);
  assign hit_time = (od_index == IDX_TIME);
  assign hit_cfg = (od_index == IDX_CFG);
  assign ring = (layout_q == LAYOUT_RING); // [R7]
  assign limit = clamp_size(fill_cfg_q);

  // set-point intake: process data has priority over a dictionary write
  always_comb begin
    od_sp = od_wr && hit_rec && (od_sub == SUB_SETPOINT) && !pdo_wr;
    // a record is only taken while access is open and 4-byte records are set
    accept = access_q && (recsize_q == RECORD_BYTES) && (ring || cnt < limit); // [R9] [R11]
    push = accept && (pdo_wr || od_sp);
    push_data = pdo_wr ? pdo_setpoint : od_wdata;
    // a full ring drops its oldest record to make room
    overwrite = push && ring && (cnt >= limit) && out_s.valid; // [R7]
    // one record per sync, only in interpolated operation
    sync_pop = sync && interp_active && out_s.valid; // [R1] [R2]
    in_s.valid = push;
    in_s.data = push_data;
    out_s.ready = sync_pop || overwrite;
  end

  // dictionary writes update configuration; flush codes steer access
  always_comb begin
    mantissa_d = mantissa_q;
    exponent_d = exponent_q;
    fill_cfg_d = fill_cfg_q;
    layout_d = layout_q;
    recsize_d = recsize_q;
    access_d = access_q;
    last_sp_d = last_sp_q;
    flush = 1'b0;
    if (push) begin
      last_sp_d = push_data;
    end
    if (od_wr && hit_time && od_sub == SUB_MANTISSA) begin
      mantissa_d = od_wdata[7:0];
    end
    if (od_wr && hit_time && od_sub == SUB_EXPONENT) begin
      exponent_d = od_wdata[7:0];
    end
    if (od_wr && hit_cfg) begin
      unique case (od_sub)
        SUB_FILL: fill_cfg_d = od_wdata;
        SUB_LAYOUT: begin
          if (od_wdata[7:0] == LAYOUT_FIFO || od_wdata[7:0] == LAYOUT_RING) begin
            layout_d = od_wdata[7:0]; // [R7]
          end
        end
        SUB_RECSIZE: recsize_d = od_wdata[7:0]; // [R9]
        SUB_FLUSH: begin
          if (od_wdata[7:0] == FLUSH_CLEAR) begin
            flush = 1'b1; // [R10]
            access_d = 1'b0; // [R10]
          end else if (od_wdata[7:0] == FLUSH_ENABLE) begin
            access_d = 1'b1; // [R11]
          end
        end
        default: ;
      endcase
    end
  end

  // fill after this cycle, used for the pointer and the ready flag
  always_comb begin
    ring_n = (layout_d == LAYOUT_RING);
    limit_n = clamp_size(fill_cfg_d);
    if (flush) begin
      cnt_n = '0;
    end else begin
      cnt_n = cnt + CNT_W'(push) - CNT_W'(sync_pop || overwrite);
    end
  end

  // next free slot, one-based
  always_comb begin
    ready_d = access_d && (recsize_d == RECORD_BYTES) && (ring_n || cnt_n < limit_n);
    slot_d = slot_q;
    if (flush) begin
      slot_d = SLOT_RST;
    end else if (od_wr && hit_cfg && od_sub == SUB_SLOT) begin
      slot_d = od_wdata[15:0]; // [R8]
    end else if (ring) begin
      if (push) begin
        // wrap after the configured size, never past the buffer
        slot_d = (slot_q >= 16'(limit)) ? 16'h0001 : slot_q + 16'h0001; // [R13]
      end
    end else begin
      slot_d = 16'(cnt_n) + 16'h0001; // [R8]
    end
  end

  // demand position is only refreshed at a sync instant
  always_comb begin
    demand_d = demand_pos_q;
    dvalid_d = 1'b0;
    if (sync_pop) begin
      demand_d = out_s.data; // [R2]
      dvalid_d = 1'b1;
    end
  end

  // dictionary answer, one cycle after the request
  always_comb begin
    rdata_d = 32'h0;
    ack_d = od_wr || od_rd;
    err_d = 1'b0;
    if (od_rd) begin
      if (hit_rec) begin
        unique case (od_sub)
          SUB_COUNT: rdata_d = {24'h0, RECORD_COUNT_VAL};
          SUB_SETPOINT: rdata_d = last_sp_q;
          default: err_d = 1'b1;
        endcase
      end else if (hit_time) begin
        unique case (od_sub)
          SUB_COUNT: rdata_d = {24'h0, TIME_COUNT_VAL};
          SUB_MANTISSA: rdata_d = {24'h0, mantissa_q};
          SUB_EXPONENT: rdata_d = {24'h0, exponent_q};
          default: err_d = 1'b1;
        endcase
      end else if (hit_cfg) begin
        unique case (od_sub) // [R12]
          SUB_COUNT: rdata_d = {24'h0, CFG_COUNT_VAL};
          SUB_CAPACITY: rdata_d = 32'(BUF_DEPTH); // [R5]
          SUB_FILL: rdata_d = {27'h0, cnt}; // [R6]
          SUB_LAYOUT: rdata_d = {24'h0, layout_q};
          SUB_SLOT: rdata_d = {16'h0, slot_q}; // [R8]
          default: err_d = 1'b1; // write-only and unknown entries
        endcase
      end else begin
        err_d = 1'b1;
      end
    end else if (od_wr) begin
      if (hit_rec) begin
        err_d = !(od_sp && push); // a process-data write in the same cycle wins
      end else if (hit_time) begin
        err_d = (od_sub != SUB_MANTISSA) && (od_sub != SUB_EXPONENT);
      end else if (hit_cfg) begin
        unique case (od_sub)
          SUB_FILL, SUB_SLOT, SUB_RECSIZE: err_d = 1'b0;
          SUB_LAYOUT: err_d = (od_wdata[7:0] != LAYOUT_FIFO) && (od_wdata[7:0] != LAYOUT_RING);
          SUB_FLUSH: err_d = (od_wdata[7:0] != FLUSH_CLEAR) && (od_wdata[7:0] != FLUSH_ENABLE);
          default: err_d = 1'b1; // read-only entries
        endcase
      end else begin
        err_d = 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mantissa_q <= MANTISSA_RST;
      exponent_q <= EXPONENT_RST; // [R4]
      fill_cfg_q <= FILL_CFG_RST;
      layout_q <= LAYOUT_RST;
      slot_q <= SLOT_RST;
      recsize_q <= RECSIZE_RST;
      access_q <= 1'b0;
      last_sp_q <= 32'h0;
    end else begin
      mantissa_q <= mantissa_d;
      exponent_q <= exponent_d;
      fill_cfg_q <= fill_cfg_d;
      layout_q <= layout_d;
      slot_q <= slot_d;
      recsize_q <= recsize_d;
      access_q <= access_d;
      last_sp_q <= last_sp_d;
    end
  end

  // output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      od_rdata_q <= 32'h0;
      od_ack_q <= 1'b0;
      od_err_q <= 1'b0;
      pdo_ready_q <= 1'b0;
      demand_pos_q <= 32'h0;
      demand_valid_q <= 1'b0;
      cycle_ns_q <= '0;
      cycle_ok_q <= 1'b0;
      buffer_access_q <= 1'b0;
    end else begin
      od_rdata_q <= rdata_d;
      od_ack_q <= ack_d;
      od_err_q <= err_d;
      pdo_ready_q <= ready_d;
      demand_pos_q <= demand_d;
      demand_valid_q <= dvalid_d;
      cycle_ns_q <= cyc_ns; // [R3]
      cycle_ok_q <= cyc_ok;
      buffer_access_q <= access_d;
    end
  end
endmodule
`default_nettype wire

// *** tb/isb_setpoint_buffer_chk.sv ***
// port checker for the interpolation set-point buffer
`timescale 1ns/1ns
`default_nettype none
module isb_setpoint_buffer_chk
  import isb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // dictionary port
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  input wire logic [31:0] od_rdata_q,
  input wire logic od_ack_q,
  input wire logic od_err_q,
  // buffer and motion side
  input wire logic pdo_ready_q,
  input wire logic sync,
  input wire logic interp_active,
  input wire logic [31:0] demand_pos_q,
  input wire logic demand_valid_q,
  input wire logic buffer_access_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // write of one configuration entry with an 8-bit code
  sequence s_cfg_wr(logic [7:0] s, logic [7:0] v);
    od_wr && od_index == IDX_CFG && od_sub == s && od_wdata[7:0] == v;
  endsequence
  // accepted answer
  sequence s_ok;
    od_ack_q && !od_err_q;
  endsequence
  property p_ack_follows;
    (od_wr || od_rd) |=> od_ack_q;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not answered");
  property p_no_stray_ack;
    !(od_wr || od_rd) |=> !od_ack_q;
  endproperty
  a_no_stray_ack: assert property (p_no_stray_ack) else $error("answer without request");
  property p_flush_clear;
    s_cfg_wr(SUB_FLUSH, FLUSH_CLEAR) |=> s_ok ##0 (!buffer_access_q && !pdo_ready_q);
  endproperty
  a_flush_clear: assert property (p_flush_clear) else $error("clear left access open");
  property p_flush_open;
    s_cfg_wr(SUB_FLUSH, FLUSH_ENABLE) |=> s_ok ##0 buffer_access_q;
  endproperty
  a_flush_open: assert property (p_flush_open) else $error("enable did not open access");
  // access only moves on a flush write, so no other entry can leak into it
  property p_access_cause;
    $changed(buffer_access_q) |-> $past(od_wr && od_index == IDX_CFG && od_sub == SUB_FLUSH);
  endproperty
  a_access_cause: assert property (p_access_cause) else $error("access moved on its own");
  property p_ready_needs_access;
    pdo_ready_q |-> buffer_access_q;
  endproperty
  a_ready_needs_access: assert property (p_ready_needs_access) else $error("ready while closed");
  property p_no_pop;
    !(sync && interp_active) |=> !demand_valid_q && $stable(demand_pos_q);
  endproperty
  a_no_pop: assert property (p_no_pop) else $error("demand moved without sync");
  property p_capacity;
    od_rd && od_index == IDX_CFG && od_sub == SUB_CAPACITY |=> s_ok ##0 od_rdata_q == 32'h10;
  endproperty
  a_capacity: assert property (p_capacity) else $error("capacity read wrong");
  property p_wo_refused;
    od_rd && od_index == IDX_CFG && (od_sub == SUB_RECSIZE || od_sub == SUB_FLUSH)
      |=> od_ack_q && od_err_q;
  endproperty
  a_wo_refused: assert property (p_wo_refused) else $error("write-only entry was read");
endmodule
bind isb_setpoint_buffer isb_setpoint_buffer_chk i_chk (
  .clk(clk), .rst(rst), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
  .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata_q(od_rdata_q), .od_ack_q(od_ack_q),
  .od_err_q(od_err_q), .pdo_ready_q(pdo_ready_q), .sync(sync),
  .interp_active(interp_active), .demand_pos_q(demand_pos_q),
  .demand_valid_q(demand_valid_q), .buffer_access_q(buffer_access_q)
);
`default_nettype wire

// *** tb/isb_host_model.sv ***
// host model pushing set-points over mapped process data
`timescale 1ns/1ns
`default_nettype none
module isb_host_model (
  // clock
  input wire logic clk,
  // process-data side
  input wire logic pdo_ready_q,
  output logic pdo_wr,
  output logic [31:0] pdo_setpoint
);
  // idle at start
  initial begin
    pdo_wr = 1'h0;
    pdo_setpoint = 32'h0;
  end
  // one record per write; keep leaves the strobe up for a back-to-back record
  task automatic push(input logic [31:0] v, input int gap, input bit keep, output bit ok);
    int n;
    n = 0;
    repeat (gap) @(negedge clk);
    pdo_wr = 1'h1;
    pdo_setpoint = v;
    // ready is settled at the falling edge and is what the next rising edge takes
    while (pdo_ready_q !== 1'h1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    ok = (pdo_ready_q === 1'h1);
    @(posedge clk);
    @(negedge clk);
    // released data is inverted so a stale word never looks valid
    if (!keep || !ok) begin
      pdo_wr = 1'h0;
      pdo_setpoint = ~v;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the interpolation set-point buffer
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import isb_pkg::*;
;
  logic clk, rst, od_wr, od_rd, sync, interp_active;
  logic [15:0] od_index;
  logic [7:0] od_sub;
  logic [31:0] od_wdata, od_rdata_q, pdo_setpoint, demand_pos_q;
  logic od_ack_q, od_err_q, pdo_wr, pdo_ready_q, demand_valid_q, cycle_ok_q, buffer_access_q;
  logic [CYC_W-1:0] cycle_ns_q;
  int miscompares = 0;
  int num_checks = 0;
  bit ok;
  isb_setpoint_buffer i_dut (
    .clk(clk), .rst(rst), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata_q(od_rdata_q), .od_ack_q(od_ack_q),
    .od_err_q(od_err_q), .pdo_wr(pdo_wr), .pdo_setpoint(pdo_setpoint),
    .pdo_ready_q(pdo_ready_q), .sync(sync), .interp_active(interp_active),
    .demand_pos_q(demand_pos_q), .demand_valid_q(demand_valid_q),
    .cycle_ns_q(cycle_ns_q), .cycle_ok_q(cycle_ok_q), .buffer_access_q(buffer_access_q)
  );
  isb_host_model i_host (.clk(clk), .pdo_ready_q(pdo_ready_q), .pdo_wr(pdo_wr),
    .pdo_setpoint(pdo_setpoint));
  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one dictionary request, answer judged in its single ack cycle
  task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, input logic e);
    @(negedge clk);
    od_wr = w;
    od_rd = !w;
    od_index = i;
    od_sub = s;
    od_wdata = w ? d : 32'h0;
    @(negedge clk);
    od_wr = 1'h0;
    od_rd = 1'h0;
    chk("answer", {od_ack_q, od_err_q}, {1'h1, e});
    if (!w && !e) chk("read data", od_rdata_q, d);
  endtask
  // one sync pulse; a pop shows one cycle later
  task automatic tick(input logic v, input logic [31:0] p);
    @(negedge clk);
    sync = 1'h1;
    @(negedge clk);
    sync = 1'h0;
    chk("pop", demand_valid_q, v);
    if (v) chk("demand", demand_pos_q, p);
  endtask
  task automatic t_reset();
    logic [55:0] tbl [9];
    tbl = '{{IDX_RECORD, SUB_COUNT, 32'h1}, {IDX_TIME, SUB_COUNT, 32'h2},
      {IDX_TIME, SUB_MANTISSA, 32'h1}, {IDX_TIME, SUB_EXPONENT, 32'hfd},
      {IDX_CFG, SUB_COUNT, 32'h6}, {IDX_CFG, SUB_CAPACITY, 32'h10}, {IDX_CFG, SUB_FILL, 32'h0},
      {IDX_CFG, SUB_LAYOUT, 32'h0}, {IDX_CFG, SUB_SLOT, 32'h1}};
    foreach (tbl[k]) od(1'h0, tbl[k][55:40], tbl[k][39:32], tbl[k][31:0], 1'h0);
    od(1'h0, IDX_CFG, SUB_RECSIZE, 32'h0, 1'h1);
    od(1'h0, IDX_CFG, SUB_FLUSH, 32'h0, 1'h1);
    od(1'h1, IDX_CFG, SUB_CAPACITY, 32'h5, 1'h1);
    od(1'h1, IDX_CFG, SUB_LAYOUT, 32'h2, 1'h1);
    chk("cycle", cycle_ns_q, 40'hf4240);
    chk("closed", {buffer_access_q, pdo_ready_q}, 2'h0);
    $display("test reset done");
  endtask
  task automatic t_cycle();
    od(1'h1, IDX_TIME, SUB_MANTISSA, 32'h5, 1'h0);
    @(negedge clk);
    chk("cycle", cycle_ns_q, 40'h4c4b40);
    od(1'h1, IDX_TIME, SUB_EXPONENT, 32'hfe, 1'h0);
    @(negedge clk);
    chk("cycle", cycle_ns_q, 40'h2faf080);
    od(1'h1, IDX_TIME, SUB_EXPONENT, 32'h1, 1'h0);
    @(negedge clk);
    chk("cycle ok", cycle_ok_q, 1'h0);
    od(1'h1, IDX_TIME, SUB_MANTISSA, 32'h1, 1'h0);
    od(1'h1, IDX_TIME, SUB_EXPONENT, 32'hfd, 1'h0);
    @(negedge clk);
    chk("cycle", cycle_ns_q, 40'hf4240);
    chk("cycle ok", cycle_ok_q, 1'h1);
    $display("test cycle done");
  endtask
  task automatic t_fifo();
    od(1'h1, IDX_CFG, SUB_FLUSH, 32'h1, 1'h0);
    od(1'h1, IDX_CFG, SUB_FILL, 32'h10, 1'h0);
    for (int k = 0; k < 16; k++) begin
      i_host.push(32'h100 + k, 0, k < 15, ok);
      chk("pushed", ok, 1'h1);
    end
    i_host.push(32'h1ff, 2, 1'h0, ok);
    chk("full refused", ok, 1'h0);
    od(1'h0, IDX_CFG, SUB_FILL, 32'h10, 1'h0);
    od(1'h0, IDX_CFG, SUB_SLOT, 32'h11, 1'h0);
    tick(1'h0, 32'h0);
    interp_active = 1'h1;
    for (int k = 0; k < 16; k++) tick(1'h1, 32'h100 + k);
    tick(1'h0, 32'h0);
    od(1'h0, IDX_CFG, SUB_FILL, 32'h0, 1'h0);
    $display("test fifo done");
  endtask
  task automatic t_ring();
    od(1'h1, IDX_CFG, SUB_LAYOUT, 32'h1, 1'h0);
    od(1'h1, IDX_CFG, SUB_FILL, 32'h4, 1'h0);
    for (int k = 0; k < 6; k++) begin
      i_host.push(32'ha0 + k, 1, 1'h0, ok);
      chk("ring push", ok, 1'h1);
    end
    od(1'h0, IDX_CFG, SUB_SLOT, 32'h3, 1'h0);
    od(1'h0, IDX_CFG, SUB_FILL, 32'h4, 1'h0);
    od(1'h0, IDX_CFG, SUB_LAYOUT, 32'h1, 1'h0);
    for (int k = 2; k < 6; k++) tick(1'h1, 32'ha0 + k);
    od(1'h1, IDX_CFG, SUB_SLOT, 32'h2, 1'h0);
    od(1'h0, IDX_CFG, SUB_SLOT, 32'h2, 1'h0);
    od(1'h1, IDX_CFG, SUB_LAYOUT, 32'h0, 1'h0);
    $display("test ring done");
  endtask
  task automatic t_flush();
    i_host.push(32'h55, 0, 1'h0, ok);
    chk("pushed", ok, 1'h1);
    od(1'h1, IDX_RECORD, SUB_SETPOINT, 32'h12345678, 1'h0);
    od(1'h0, IDX_RECORD, SUB_SETPOINT, 32'h12345678, 1'h0);
    od(1'h0, IDX_CFG, SUB_FILL, 32'h2, 1'h0);
    od(1'h1, IDX_CFG, SUB_FLUSH, 32'h0, 1'h0);
    chk("closed", {buffer_access_q, pdo_ready_q}, 2'h0);
    od(1'h0, IDX_CFG, SUB_FILL, 32'h0, 1'h0);
    od(1'h0, IDX_CFG, SUB_SLOT, 32'h1, 1'h0);
    od(1'h1, IDX_RECORD, SUB_SETPOINT, 32'h9, 1'h1);
    tick(1'h0, 32'h0);
    od(1'h1, IDX_CFG, SUB_RECSIZE, 32'h8, 1'h0);
    od(1'h1, IDX_CFG, SUB_FLUSH, 32'h1, 1'h0);
    chk("ready", pdo_ready_q, 1'h0);
    od(1'h1, IDX_CFG, SUB_RECSIZE, 32'h4, 1'h0);
    @(negedge clk);
    chk("open", {buffer_access_q, pdo_ready_q}, 2'h3);
    $display("test flush done");
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst = 1'h1;
    {od_wr, od_rd, sync, interp_active} = 4'h0;
    od_index = 16'h0;
    od_sub = 8'h0;
    od_wdata = 32'h0;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_cycle();
    t_fifo();
    t_ring();
    t_flush();
    wrap_up();
  end
  // hang guard, well above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
